/* File: verilog/stm_monitor.sv */
// AXI4-Lite controlled supply threshold monitor
`timescale 1ns/1ps
`default_nettype none
module stm_monitor #(
    parameter int CLK_HZ = stm_pkg::STM_CLK_HZ
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Analog comparator
    input  wire logic        compare_in,
    output logic             monitor_powerdown,
    output logic [4:0]       trigger_level,
    output logic             monitor_input_select
);
    import stm_pkg::*;

    // ==========================================================
    // Comparator input synchroniser
    logic [2:0] sync_reg;
    logic       compare_result_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_reg           <= 3'h0;
            compare_result_reg <= 1'h0;
        end else begin
            sync_reg <= {sync_reg[1:0], compare_in};
            if (sync_reg[1] == sync_reg[2]) begin
                compare_result_reg <= sync_reg[2];
            end
        end
    end

    // ==========================================================
    // Settling timer
    logic pd_reg;
    logic settled;
    stm_settle_timer #(.CLK_HZ(CLK_HZ)) u_timer (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .powerdown (pd_reg),
        .settled   (settled)
    );

    // ==========================================================
    // Write channel
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [15:0] awaddr_reg;
    logic [7:0]  wbyte_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic [4:0]  level_reg;
    logic        sel_reg;

    wire logic aw_take = s_axi_awvalid && !aw_held_reg && !bvalid_reg;
    wire logic w_take  = s_axi_wvalid && !w_held_reg && !bvalid_reg;
    wire logic aw_have = aw_held_reg || aw_take;
    wire logic w_have  = w_held_reg || w_take;
    wire logic wr_go   = aw_have && w_have && !bvalid_reg;
    wire logic [15:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    wire logic [7:0]  wr_byte = w_held_reg ? wbyte_reg : s_axi_wdata[7:0];
    wire logic        wr_lane = w_held_reg ? 1'h1 : s_axi_wstrb[0];
    logic             wlane_reg;
    wire logic        wr_en   = w_held_reg ? wlane_reg : wr_lane;
    wire logic wr_ctl = wr_go && (wr_addr == STM_ADDR_CONTROL) && wr_en;
    wire logic wr_sel = wr_go && (wr_addr == STM_ADDR_INPUTSEL) && wr_en;
    wire logic wr_ok  = (wr_addr == STM_ADDR_CONTROL)
                     || (wr_addr == STM_ADDR_INPUTSEL);
    wire logic aw_held_next = wr_go ? 1'h0 : aw_have;
    wire logic w_held_next  = wr_go ? 1'h0 : w_have;
    wire logic bvalid_next  = wr_go || (bvalid_reg && !s_axi_bready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'h0;
            w_held_reg  <= 1'h0;
            awaddr_reg  <= 16'h0000;
            wbyte_reg   <= 8'h00;
            wlane_reg   <= 1'h0;
            bvalid_reg  <= 1'h0;
            bresp_reg   <= STM_RESP_OKAY;
        end else begin
            if (aw_take) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                wbyte_reg <= s_axi_wdata[7:0];
                wlane_reg <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_held_reg <= 1'h0;
                w_held_reg  <= 1'h0;
                bvalid_reg  <= 1'h1;
                bresp_reg   <= wr_ok ? STM_RESP_OKAY : STM_RESP_SLVERR;
            end else begin
                aw_held_reg <= aw_have;
                w_held_reg  <= w_have;
                if (bvalid_reg && s_axi_bready) begin
                    bvalid_reg <= 1'h0;
                end
            end
        end
    end

    // ==========================================================
    // Control and input select registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_reg <= STM_LEVEL_RESET;
            pd_reg    <= STM_PD_RESET;
            sel_reg   <= STM_SEL_RESET;
        end else begin
            if (wr_ctl) begin
                level_reg <= wr_byte[STM_LEVEL_HI:STM_LEVEL_LO];
                pd_reg    <= wr_byte[STM_BIT_PD];
            end
            if (wr_sel) begin
                sel_reg <= wr_byte[0];
            end
        end
    end

    // ==========================================================
    // Read channel
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;

    wire logic result_bit = compare_result_reg && !pd_reg && settled;
    wire logic [7:0] ctl_word = {1'h0, result_bit, level_reg, pd_reg};
    wire logic level_low = (level_reg < STM_LEVEL_MIN);
    wire logic coarse    = (level_reg > STM_LEVEL_KNEE);
    wire logic [31:0] status_word = {28'h0000000, coarse, level_low,
                                     settled, !pd_reg};
    wire logic rd_take = s_axi_arvalid && !rvalid_reg;
    wire logic rvalid_next = rd_take || (rvalid_reg && !s_axi_rready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'h0;
            rdata_reg  <= 32'h00000000;
            rresp_reg  <= STM_RESP_OKAY;
        end else if (rd_take) begin
            rvalid_reg <= 1'h1;
            rresp_reg  <= STM_RESP_OKAY;
            unique case (s_axi_araddr)
                STM_ADDR_CONTROL:  rdata_reg <= {24'h000000, ctl_word};
                STM_ADDR_INPUTSEL: rdata_reg <= {31'h00000000, sel_reg};
                STM_ADDR_STATUS:   rdata_reg <= status_word;
                default: begin
                    rdata_reg <= 32'h00000000;
                    rresp_reg <= STM_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'h0;
        end
    end

    // ==========================================================
    // Outputs from flip-flops
    logic awready_reg;
    logic wready_reg;
    logic arready_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'h1;
            wready_reg  <= 1'h1;
            arready_reg <= 1'h1;
        end else begin
            // Readies follow the next channel state, one flop deep
            awready_reg <= !aw_held_next && !bvalid_next;
            wready_reg  <= !w_held_next && !bvalid_next;
            arready_reg <= !rvalid_next;
        end
    end

    assign s_axi_awready        = awready_reg;
    assign s_axi_wready         = wready_reg;
    assign s_axi_arready        = arready_reg;
    assign s_axi_bvalid         = bvalid_reg;
    assign s_axi_bresp          = bresp_reg;
    assign s_axi_rvalid         = rvalid_reg;
    assign s_axi_rdata          = rdata_reg;
    assign s_axi_rresp          = rresp_reg;
    assign monitor_powerdown    = pd_reg;
    assign trigger_level        = level_reg;
    assign monitor_input_select = sel_reg;
endmodule // stm_monitor
`default_nettype wire

/* File: verilog/stm_pkg.sv */
// Package of constants for the supply threshold monitor
package stm_pkg;
    // ==========================================================
    // Register map
    localparam logic [15:0] STM_ADDR_CONTROL  = 16'h6264;
    localparam logic [15:0] STM_ADDR_INPUTSEL = 16'h6268;
    localparam logic [15:0] STM_ADDR_STATUS   = 16'h626c;
    // ==========================================================
    // Control register fields
    localparam int          STM_BIT_RESERVED  = 7;
    localparam int          STM_BIT_RESULT    = 6;
    localparam int          STM_LEVEL_HI      = 5;
    localparam int          STM_LEVEL_LO      = 1;
    localparam int          STM_BIT_PD        = 0;
    localparam logic [4:0]  STM_LEVEL_RESET   = 5'h1c;
    localparam logic        STM_PD_RESET      = 1'h1;
    localparam logic [4:0]  STM_LEVEL_MIN     = 5'h03;
    localparam logic [4:0]  STM_LEVEL_KNEE    = 5'h1a;
    localparam logic        STM_SEL_RESET     = 1'h0;
    // ==========================================================
    // Threshold ladder in millivolts
    localparam int          STM_BASE_MV       = 1930;
    localparam int          STM_FINE_STEP_MV  = 24;
    localparam int          STM_COARSE_STEP_MV = 169;
    // ==========================================================
    // Settling time
    localparam int          STM_SETTLE_NS     = 2000;
    localparam int          STM_CLK_HZ        = 10000000;
    localparam logic [1:0]  STM_RESP_OKAY     = 2'h0;
    localparam logic [1:0]  STM_RESP_SLVERR   = 2'h2;
endpackage : stm_pkg

/* File: verilog/stm_settle_timer.sv */
// Settling timer counting enabled cycles of the comparator
`timescale 1ns/1ps
`default_nettype none
module stm_settle_timer #(
    parameter int CLK_HZ = stm_pkg::STM_CLK_HZ
) (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Control and status
    input  wire logic powerdown,
    output logic      settled
);
    import stm_pkg::*;
    // Least time rounds up
    localparam longint CYCLES =
        (longint'(STM_SETTLE_NS) * CLK_HZ + 999999999) / 1000000000;
    localparam int SETTLE_CYCLES = (CYCLES < 1) ? 1 : int'(CYCLES);
    localparam int CW = $clog2(SETTLE_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(SETTLE_CYCLES);

    logic [CW-1:0] count_reg;
    wire  logic    done = (count_reg == LAST);

    always_ff @(posedge aclk) begin
        if (!aresetn || powerdown) begin
            count_reg <= '0;
        end else if (!done) begin
            count_reg <= count_reg + CW'(1);
        end
    end

    assign settled = done;
endmodule // stm_settle_timer
`default_nettype wire

/* File: verification/stm_monitor_properties.sv */
// Checker for the register bus and control outputs of the monitor
`timescale 1ns/1ps
`default_nettype none
module stm_monitor_properties #(
    parameter int CLK_HZ = 10000000
) (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic [15:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Comparator side
    input wire logic        compare_in,
    input wire logic        monitor_powerdown,
    input wire logic [4:0]  trigger_level,
    input wire logic        monitor_input_select
);
    localparam int SETTLE = 2 * CLK_HZ / 1000000;
    logic [5:0] en_cnt;
    wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                 && s_axi_wready && s_axi_wstrb[0];
    wire wr_ctl = wr_go && s_axi_awaddr == 16'h6264;
    wire wr_sel = wr_go && s_axi_awaddr == 16'h6268;
    wire rd_bad = s_axi_araddr != 16'h6264 && s_axi_araddr != 16'h6268
                  && s_axi_araddr != 16'h626c;
    // Cycles spent enabled, restarted by power-down
    always_ff @(posedge aclk) begin
        if (!aresetn || monitor_powerdown) en_cnt <= '0;
        else if (en_cnt != 6'h3f) en_cnt <= en_cnt + 6'h01;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    rsv_read_zero_a: assert property (
        s_axi_rvalid |-> !s_axi_rdata[7])
        else $error("reserved bit read as one");
    // Data is captured on the edge that raises rvalid, from the cycle before, hence the bound
    early_result_a: assert property (
        $rose(s_axi_rvalid) && en_cnt <= SETTLE |-> !s_axi_rdata[6])
        else $error("result shown before settling");
    reset_values_a: assert property (disable iff (1'b0)
        !aresetn |=> monitor_powerdown && trigger_level == 5'h1c
            && !monitor_input_select && !s_axi_bvalid && !s_axi_rvalid
            && s_axi_awready && s_axi_wready && s_axi_arready)
        else $error("wrong values after reset");
    write_answer_a: assert property (
        wr_go |=> s_axi_bvalid)
        else $error("no write response");
    read_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read response");
    read_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready
            |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    write_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready
            |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    ctrl_write_a: assert property (
        wr_ctl |=> trigger_level == $past(s_axi_wdata[5:1])
            && monitor_powerdown == $past(s_axi_wdata[0]))
        else $error("control write not applied");
    select_write_a: assert property (
        wr_sel |=> monitor_input_select == $past(s_axi_wdata[0]))
        else $error("select write not applied");
    bad_read_a: assert property (
        s_axi_arvalid && s_axi_arready && rd_bad
            |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");
endmodule // stm_monitor_properties
bind stm_monitor stm_monitor_properties #(.CLK_HZ(CLK_HZ)) u_props (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .s_axi_awaddr         (s_axi_awaddr),
    .s_axi_awvalid        (s_axi_awvalid),
    .s_axi_awready        (s_axi_awready),
    .s_axi_wdata          (s_axi_wdata),
    .s_axi_wstrb          (s_axi_wstrb),
    .s_axi_wvalid         (s_axi_wvalid),
    .s_axi_wready         (s_axi_wready),
    .s_axi_bresp          (s_axi_bresp),
    .s_axi_bvalid         (s_axi_bvalid),
    .s_axi_bready         (s_axi_bready),
    .s_axi_araddr         (s_axi_araddr),
    .s_axi_arvalid        (s_axi_arvalid),
    .s_axi_arready        (s_axi_arready),
    .s_axi_rdata          (s_axi_rdata),
    .s_axi_rresp          (s_axi_rresp),
    .s_axi_rvalid         (s_axi_rvalid),
    .s_axi_rready         (s_axi_rready),
    .compare_in           (compare_in),
    .monitor_powerdown    (monitor_powerdown),
    .trigger_level        (trigger_level),
    .monitor_input_select (monitor_input_select)
);
`default_nettype wire

/* File: verification/stm_monitor_bench.sv */
// Self-checking bench for the supply threshold monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; \
    if ((g) !== (e)) begin failures++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module stm_monitor_bench;
    import stm_pkg::*;
    localparam logic [15:0] C = STM_ADDR_CONTROL, S = STM_ADDR_INPUTSEL;
    localparam logic [1:0] OK = STM_RESP_OKAY, ER = STM_RESP_SLVERR;
    // Response readies stay high, so each answer is taken when it shows
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 1;
    logic arvalid = 0, rready = 1, cmp = 0, awready, wready, bvalid;
    logic arready, rvalid, pd, sel;
    logic [15:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = '0;
    logic [1:0] bresp, rresp;
    logic [4:0] lvl;
    logic [4:0] codes [4] = '{5'h03, 5'h1a, 5'h1b, 5'h1f};
    int failures = 0, comparisons = 0;
    always #50 aclk = ~aclk;
    stm_monitor DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .compare_in(cmp),
        .monitor_powerdown(pd), .trigger_level(lvl),
        .monitor_input_select(sel));
    task automatic results;
        $display("Counts: %0d compared, %0d failed", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Handshakes are decided at the falling edge, acted on at the rising
    task automatic wr(input logic [15:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] e);
        int n; logic ta, tw, tb; logic [1:0] r;
        n = 0; tb = 0;
        awaddr <= a; wdata <= d; wstrb <= s;
        awvalid <= 1; wvalid <= 1;
        while (!tb) begin
            @(negedge aclk);
            ta = awvalid && awready; tw = wvalid && wready;
            tb = bvalid; r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
            if (++n > 50) begin failures++; results; end
        end
        `CHK(r, e)
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] x,
                      input logic [1:0] e);
        int n; logic ta, tr; logic [31:0] d; logic [1:0] r;
        n = 0; tr = 0;
        araddr <= a; arvalid <= 1;
        while (!tr) begin
            @(negedge aclk);
            ta = arvalid && arready; tr = rvalid; d = rdata; r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 0;
            if (++n > 50) begin failures++; results; end
        end
        `CHK(d, x)
        `CHK(r, e)
    endtask
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        rd(C, 32'h39, OK);
        rd(S, 32'h0, OK);
        wr(C, 32'hff, 4'h1, OK);
        rd(C, 32'h3f, OK);
        rd(STM_ADDR_STATUS, 32'h8, OK);
        foreach (codes[i]) begin
            wr(C, {26'h0, codes[i], 1'b1}, 4'h1, OK);
            `CHK(lvl, codes[i])
        end
        $display("Test done: register fields");
        cmp <= 1;
        wr(C, 32'h06, 4'h1, OK);
        rd(C, 32'h06, OK);
        repeat (25) @(posedge aclk);
        rd(C, 32'h46, OK);
        cmp <= 0;
        repeat (8) @(posedge aclk);
        rd(C, 32'h06, OK);
        wr(C, 32'h07, 4'h1, OK);
        `CHK(pd, 1'b1)
        $display("Test done: settling and result");
        cmp <= 1;
        wr(C, 32'h06, 4'h1, OK);
        repeat (10) @(posedge aclk);
        wr(C, 32'h07, 4'h1, OK);
        wr(C, 32'h06, 4'h1, OK);
        repeat (10) @(posedge aclk);
        rd(C, 32'h06, OK);
        repeat (25) @(posedge aclk);
        wr(S, 32'h1, 4'h1, OK);
        `CHK(sel, 1'b1)
        rd(S, 32'h1, OK);
        rd(C, 32'h46, OK);
        rd(STM_ADDR_STATUS, 32'h3, OK);
        $display("Test done: restart and select");
        wr(16'h6000, 32'h1, 4'h1, ER);
        rd(16'h6000, 32'h0, ER);
        wr(C, 32'h01, 4'h0, OK);
        rd(C, 32'h46, OK);
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        rd(C, 32'h39, OK);
        $display("Test done: errors and reset");
        results;
    end
endmodule // stm_monitor_bench
`default_nettype wire
